// *** core/index_op_defs.svh ***
`ifndef INDEX_OP_DEFS_SVH
`define INDEX_OP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------------
`define IDX_CTRL_OFS 6'h00
`define IDX_STATUS_OFS 6'h04
`define IDX_FLAGS_OFS 6'h08
`define IDX_REGS_LO_OFS 6'h0c
`define IDX_REGS_HI_OFS 6'h10
`define IDX_COND_OFS 6'h14

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define IDX_CTRL_GO_BIT 16
`define IDX_STAT_BUSY_BIT 0
`define IDX_STAT_HALT_BIT 1
`define IDX_STAT_UNSUP_BIT 2
`define IDX_FLAG_CARRY 2'b00
`define IDX_FLAG_ZERO 2'b01
`define IDX_FLAG_SIGN 2'b10
`define IDX_FLAG_PARITY 2'b11
`define IDX_REG_RESET 8'h00
`define IDX_FLAGS_RESET 4'h0

// ----------------------------------------------------------------------------
// Register codes and timing
// ----------------------------------------------------------------------------
`define IDX_CODE_A 3'b000
`define IDX_CODE_M 3'b111
`define IDX_CLKS_PER_STATE 2
`define IDX_FETCH_STATES 4'd5
`define IDX_READ_END 4'd8
`define IDX_STATES_FETCH 4'd5
`define IDX_STATES_READ 4'd8
`define IDX_STATES_WRITE 4'd7
`define IDX_STATES_RD_WR 4'd9

`endif

// *** core/index_op_pkg.sv ***
package index_op_pkg;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_FETCH = 4'b0010,
        PH_READ = 4'b0100,
        PH_WRITE = 4'b1000
    } phase_e;

    typedef enum logic [3:0] {
        OP_MOVE = 4'h0,
        OP_LOAD_MEM = 4'h1,
        OP_STORE_MEM = 4'h2,
        OP_LOAD_IMM = 4'h3,
        OP_STORE_IMM = 4'h4,
        OP_INC = 4'h5,
        OP_DEC = 4'h6,
        OP_HALT = 4'h7,
        OP_UNSUP = 4'h8
    } op_e;

    typedef struct packed {
        op_e op;
        logic [2:0] dst;
        logic [2:0] src;
        logic [3:0] states;
    } decoded_s;

    typedef struct packed {
        logic [13:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } mem_req_s;

endpackage : index_op_pkg

// *** core/index_register_op_decoder.sv ***
`timescale 1ns/100ps
`include "index_op_defs.svh"
module index_register_op_decoder (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output index_op_pkg::mem_req_s mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    output index_op_pkg::phase_e cycle_o,
    output logic halted_o,
    output logic done_o
);
    import index_op_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic decoded_s decode(input logic [7:0] opc);
        decoded_s d;
        d.dst = opc[5:3];
        d.src = opc[2:0];
        d.op = OP_UNSUP;
        d.states = `IDX_STATES_FETCH;
        if (opc[7:6] == 2'b11) begin
            if (opc[5:3] == `IDX_CODE_M && opc[2:0] == `IDX_CODE_M) begin
                d.op = OP_HALT;
            end else if (opc[2:0] == `IDX_CODE_M) begin
                d.op = OP_LOAD_MEM;
                d.states = `IDX_STATES_READ;
            end else if (opc[5:3] == `IDX_CODE_M) begin
                d.op = OP_STORE_MEM;
                d.states = `IDX_STATES_WRITE;
            end else begin
                d.op = OP_MOVE;
            end
        end else if (opc[7:6] == 2'b00) begin
            if (opc[2:0] == 3'b110) begin
                d.op = (opc[5:3] == `IDX_CODE_M) ? OP_STORE_IMM : OP_LOAD_IMM;
                d.states = (opc[5:3] == `IDX_CODE_M) ? `IDX_STATES_RD_WR
                                                     : `IDX_STATES_READ;
            end else if (opc[2:1] == 2'b00 && opc[5:3] != `IDX_CODE_M) begin
                if (opc[5:3] == `IDX_CODE_A) begin
                    d.op = OP_HALT;
                end else begin
                    d.op = opc[0] ? OP_DEC : OP_INC;
                end
            end
        end
        return d;
    endfunction : decode

    function automatic logic [3:0] result_flags(input logic [7:0] v, input logic carry);
        // Bit order follows the select codes: carry, zero, sign, parity.
        return {~^v, v[7], (v == 8'h00), carry};
    endfunction : result_flags

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [6:0][7:0] regs_r;
    logic [3:0] flags_r;
    logic [1:0] cond_sel_r;
    decoded_s dec_r;
    logic [7:0] second_byte_r;
    logic [7:0] rd_data_r;
    phase_e phase_r;
    logic [3:0] state_cnt_r;
    logic div_r;
    logic state_en;
    logic halted_r;
    logic unsup_r;
    logic done_r;
    logic ack_r;
    logic [31:0] rdata_r;
    mem_req_s mem_r;
    logic bus_req;
    logic bus_wr;
    logic start;
    logic finish;
    logic [3:0] cnt_nxt;
    logic [13:0] hl_addr;
    logic [7:0] alu_res;
    logic [31:0] regs_lo;
    logic [31:0] regs_hi;
    logic [31:0] lo_nxt;
    logic [31:0] hi_nxt;

    assign hl_addr = {regs_r[5][5:0], regs_r[6]};
    assign regs_lo = {regs_r[3], regs_r[2], regs_r[1], regs_r[0]};
    assign regs_hi = {8'h00, regs_r[6], regs_r[5], regs_r[4]};
    assign lo_nxt = lane_merge(regs_lo, avs_writedata_i, avs_byteenable_i);
    assign hi_nxt = lane_merge(regs_hi, avs_writedata_i, avs_byteenable_i);

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    // Every access waits exactly one cycle, so read data comes from a flop.
    assign bus_req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_req & ~ack_r;
    assign bus_wr = avs_write_i & ack_r;
    assign avs_readdata_o = rdata_r;
    assign start = bus_wr && avs_address_i == `IDX_CTRL_OFS && phase_r == PH_IDLE
                   && avs_writedata_i[`IDX_CTRL_GO_BIT] && avs_byteenable_i[2];

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req & ~ack_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read_i && !ack_r) begin
            unique case (avs_address_i)
                `IDX_CTRL_OFS: rdata_r <= {16'h0000, second_byte_r, 8'h00};
                `IDX_STATUS_OFS: rdata_r <= {20'h00000, state_cnt_r, phase_r,
                                             1'b0, unsup_r, halted_r, phase_r != PH_IDLE};
                `IDX_FLAGS_OFS: rdata_r <= {28'h0000000, flags_r};
                `IDX_REGS_LO_OFS: rdata_r <= regs_lo;
                `IDX_REGS_HI_OFS: rdata_r <= regs_hi;
                `IDX_COND_OFS: rdata_r <= {29'h00000000, cond_sel_r, flags_r[cond_sel_r]};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cond_sel_r <= `IDX_FLAG_CARRY;
        end else if (bus_wr && avs_address_i == `IDX_COND_OFS && avs_byteenable_i[0]) begin
            cond_sel_r <= avs_writedata_i[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // State timing
    // ------------------------------------------------------------------------
    // The divider restarts with each instruction so state edges line up with it.
    assign state_en = div_r && phase_r != PH_IDLE;
    assign cnt_nxt = state_cnt_r + 4'd1;
    assign finish = state_en && cnt_nxt == dec_r.states;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            div_r <= 1'b0;
        end else if (phase_r != PH_IDLE) begin
            div_r <= ~div_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            phase_r <= PH_IDLE;
            state_cnt_r <= 4'd0;
        end else if (start) begin
            phase_r <= PH_FETCH;
            state_cnt_r <= 4'd0;
        end else if (finish) begin
            phase_r <= PH_IDLE;
            state_cnt_r <= cnt_nxt;
        end else if (state_en) begin
            state_cnt_r <= cnt_nxt;
            if (cnt_nxt < `IDX_FETCH_STATES) begin
                phase_r <= PH_FETCH;
            end else if ((dec_r.op == OP_LOAD_MEM || dec_r.op == OP_LOAD_IMM
                          || dec_r.op == OP_STORE_IMM) && cnt_nxt < `IDX_READ_END) begin
                phase_r <= PH_READ;
            end else begin
                phase_r <= PH_WRITE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dec_r <= decode(8'hff);
            second_byte_r <= 8'h00;
        end else if (start) begin
            dec_r <= decode(avs_writedata_i[7:0]);
            second_byte_r <= avs_writedata_i[15:8];
        end
    end

    // ------------------------------------------------------------------------
    // Memory cycles
    // ------------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mem_r <= '0;
        end else begin
            mem_r.rd <= state_en && !finish && cnt_nxt == `IDX_FETCH_STATES
                        && dec_r.op == OP_LOAD_MEM;
            mem_r.wr <= state_en && !finish && phase_r != PH_WRITE
                        && (dec_r.op == OP_STORE_MEM
                            ? cnt_nxt == `IDX_FETCH_STATES
                            : dec_r.op == OP_STORE_IMM && cnt_nxt == `IDX_READ_END);
            if (state_en) begin
                mem_r.addr <= hl_addr;
                mem_r.wdata <= dec_r.op == OP_STORE_IMM ? second_byte_r
                                                        : regs_r[dec_r.src];
            end
        end
    end

    // Memory answers while the read strobe stands; the byte is taken at the edge that ends it.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_data_r <= 8'h00;
        end else if (mem_r.rd) begin
            rd_data_r <= mem_rdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // Execution
    // ------------------------------------------------------------------------
    assign alu_res = dec_r.op == OP_DEC ? regs_r[dec_r.dst] - 8'h01
                                        : regs_r[dec_r.dst] + 8'h01;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            regs_r <= {7{`IDX_REG_RESET}};
        end else if (finish) begin
            unique case (dec_r.op)
                OP_MOVE: regs_r[dec_r.dst] <= regs_r[dec_r.src];
                OP_LOAD_MEM: regs_r[dec_r.dst] <= rd_data_r;
                OP_LOAD_IMM: regs_r[dec_r.dst] <= second_byte_r;
                OP_INC, OP_DEC: regs_r[dec_r.dst] <= alu_res;
                default: regs_r <= regs_r;
            endcase
        end else if (bus_wr && phase_r == PH_IDLE) begin
            // Software may preload registers only between instructions.
            if (avs_address_i == `IDX_REGS_LO_OFS) begin
                regs_r[3:0] <= lo_nxt;
            end else if (avs_address_i == `IDX_REGS_HI_OFS) begin
                regs_r[6:4] <= hi_nxt[23:0];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags_r <= `IDX_FLAGS_RESET;
        end else if (finish && (dec_r.op == OP_INC || dec_r.op == OP_DEC)) begin
            flags_r <= result_flags(alu_res, flags_r[0]);
        end else if (bus_wr && phase_r == PH_IDLE && avs_address_i == `IDX_FLAGS_OFS
                     && avs_byteenable_i[0]) begin
            flags_r <= avs_writedata_i[3:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            halted_r <= 1'b0;
            unsup_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= finish;
            if (finish) begin
                halted_r <= dec_r.op == OP_HALT;
                unsup_r <= dec_r.op == OP_UNSUP;
            end else if (start) begin
                halted_r <= 1'b0;
                unsup_r <= 1'b0;
            end
        end
    end

    assign mem_req_o = mem_r;
    assign cycle_o = phase_r;
    assign halted_o = halted_r;
    assign done_o = done_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic [4:0] exec_clks_r;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            exec_clks_r <= 5'd0;
        end else if (phase_r != PH_IDLE) begin
            exec_clks_r <= exec_clks_r + 5'd1;
        end
    end

    state_tick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_en |=> !state_en) else $error("state tick came on two clocks in a row");
    instr_len_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        finish |-> exec_clks_r == {dec_r.states, 1'b0} - 5'd1)
        else $error("instruction length is not twice its state count");
    move_copy_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        finish && dec_r.op == OP_MOVE |=> regs_r[dec_r.dst] == $past(regs_r[dec_r.src]))
        else $error("register move lost its data");
    nop_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        finish && dec_r.op == OP_MOVE && dec_r.dst == dec_r.src |=> $stable(regs_r))
        else $error("move to itself changed a register");
    flags_kept_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        finish && dec_r.op inside {OP_MOVE, OP_LOAD_MEM, OP_STORE_MEM, OP_LOAD_IMM,
                                   OP_STORE_IMM} |=> $stable(flags_r))
        else $error("a load changed the flags");
    step_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        finish && dec_r.op == OP_INC |=> regs_r[dec_r.dst] == 8'(
            $past(regs_r[dec_r.dst]) + 8'h01))
        else $error("increment result wrong");
    flag_calc_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        finish && dec_r.op inside {OP_INC, OP_DEC} |=>
        flags_r[1] == (regs_r[dec_r.dst] == 8'h00) && flags_r[2] == regs_r[dec_r.dst][7]
        && flags_r[3] == ~^regs_r[dec_r.dst] && flags_r[0] == $past(flags_r[0]))
        else $error("step flags wrong");
    halt_alias_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        start && (avs_writedata_i[7:0] == 8'hff || avs_writedata_i[7:1] == 7'h00)
        |=> dec_r.op == OP_HALT ##[9:10] halted_r)
        else $error("halt alias not honoured");
    mem_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mem_r.wr |-> mem_r.addr == hl_addr && mem_r.wdata == (dec_r.op == OP_STORE_IMM
        ? second_byte_r : regs_r[dec_r.src]))
        else $error("memory write carries wrong address or data");
    mem_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mem_r.rd |-> mem_r.addr == hl_addr ##[5:6] done_r)
        else $error("memory read misplaced");

endmodule : index_register_op_decoder

// *** sim/mem_model.sv ***
`timescale 1ns/100ps
module mem_model (
    input wire logic clock_i,
    input wire index_op_pkg::mem_req_s req_i,
    output logic [7:0] rdata_o
);
    import index_op_pkg::*;
    logic [7:0] mem [0:16383];
    // The decoder captures read data at the edge that ends its read strobe, so the
    // byte is shown only while the strobe stands. Otherwise the bus shows its inverse,
    // so a decoder that samples early or late cannot match by luck.
    assign rdata_o = req_i.rd ? mem[req_i.addr] : ~mem[req_i.addr];
    always @(posedge clock_i) begin
        if (req_i.wr) begin
            mem[req_i.addr] <= req_i.wdata;
        end
    end
endmodule : mem_model

// *** sim/tb.sv ***
`timescale 1ns/100ps
`include "index_op_defs.svh"
module tb;
    import index_op_pkg::*;
    logic clock_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, halted_o, done_o;
    logic [5:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [3:0] avs_byteenable_i, flg;
    logic [7:0] mem_rdata_i;
    mem_req_s mem_req_o;
    phase_e cycle_o;
    int miscompares, checks_done;
    logic [7:0] rf [0:6];
    index_register_op_decoder index_register_op_decoder_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .cycle_o(cycle_o),
        .halted_o(halted_o), .done_o(done_o));
    mem_model mem_model_inst (.clock_i(clock_i), .req_i(mem_req_o), .rdata_o(mem_rdata_i));
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    // The request is held until the edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
            input logic [3:0] be);
        int n;
        @(posedge clock_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        for (n = 0; n < 50; n++) begin
            @(posedge clock_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n == 50) begin
            miscompares++;
            results();
        end
    endtask : bus
    task automatic init_rf();
        for (int i = 0; i < 7; i++) rf[i] = 8'h13 * 8'(i + 1);
    endtask : init_rf
    task automatic set_regs();
        bus(1'b1, `IDX_REGS_LO_OFS, {rf[3], rf[2], rf[1], rf[0]}, 4'hf);
        bus(1'b1, `IDX_REGS_HI_OFS, {8'h00, rf[6], rf[5], rf[4]}, 4'hf);
        bus(1'b1, `IDX_FLAGS_OFS, {28'h0, flg}, 4'h1);
    endtask : set_regs
    task automatic check_regs(input string what);
        bus(1'b0, `IDX_REGS_LO_OFS, 32'h0, 4'hf);
        chk(what, q, {rf[3], rf[2], rf[1], rf[0]});
        bus(1'b0, `IDX_REGS_HI_OFS, 32'h0, 4'hf);
        chk(what, q, {8'h00, rf[6], rf[5], rf[4]});
        bus(1'b0, `IDX_FLAGS_OFS, 32'h0, 4'hf);
        chk("flags", q[3:0], flg);
    endtask : check_regs
    // Counts clocks from the accepting edge to done and watches memory strobes.
    task automatic exec(input logic [7:0] op, input logic [7:0] b2, input int st,
            input int nrd, input int nwr);
        int n, rds, wrs;
        rds = 0;
        wrs = 0;
        bus(1'b1, `IDX_CTRL_OFS, {15'h0, 1'b1, b2, op}, 4'h7);
        for (n = 1; n < 40; n++) begin
            @(posedge clock_i);
            if (mem_req_o.rd === 1'b1) begin
                rds++;
                chk("read phase", cycle_o, PH_READ);
            end
            if (mem_req_o.wr === 1'b1) begin
                wrs++;
                chk("write phase", cycle_o, PH_WRITE);
            end
            if (done_o === 1'b1) break;
        end
        if (n == 40) begin
            miscompares++;
            results();
        end
        chk("clocks to done", n, 2 * st + 1);
        chk("read strobes", rds, nrd);
        chk("write strobes", wrs, nwr);
    endtask : exec
    function automatic logic [3:0] nf(input logic [7:0] r, input logic c);
        return {~^r, r[7], r == 8'h00, c};
    endfunction : nf
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 7; i++) rf[i] = 8'h00;
        flg = 4'h0;
        check_regs("reset regs");
        chk("reset halted", halted_o, 1'b0);
        chk("reset phase", cycle_o, PH_IDLE);
        bus(1'b0, 6'h3c, 32'h0, 4'hf);
        chk("unmapped read", q, 32'h0);
    endtask : t_reset
    task automatic t_move();
        flg = 4'b1011;
        for (int d = 0; d < 7; d++) begin
            for (int s = 0; s < 7; s++) begin
                init_rf();
                set_regs();
                exec({2'b11, 3'(d), 3'(s)}, 8'h00, 5, 0, 0);
                rf[d] = rf[s];
                check_regs("move");
            end
        end
    endtask : t_move
    task automatic t_mem();
        for (int d = 0; d < 7; d++) begin
            init_rf();
            rf[5] = 8'hea;
            rf[6] = 8'hc3;
            mem_model_inst.mem[{6'h2a, 8'hc3}] = 8'h90 + 8'(d);
            set_regs();
            exec({2'b11, 3'(d), 3'b111}, 8'h00, 8, 1, 0);
            rf[d] = 8'h90 + 8'(d);
            check_regs("load from memory");
        end
        for (int s = 0; s < 7; s++) begin
            init_rf();
            rf[5] = 8'h41;
            rf[6] = 8'h07;
            set_regs();
            exec({2'b11, 3'b111, 3'(s)}, 8'h00, 7, 0, 1);
            chk("stored byte", mem_model_inst.mem[{6'h01, 8'h07}], rf[s]);
            check_regs("store keeps source");
        end
    endtask : t_mem
    task automatic t_imm();
        for (int d = 0; d < 7; d++) begin
            exec({2'b00, 3'(d), 3'b110}, 8'h60 + 8'(d), 8, 0, 0);
            rf[d] = 8'h60 + 8'(d);
            check_regs("load immediate");
        end
        exec(8'h3e, 8'ha5, 9, 0, 1);
        chk("immediate store", mem_model_inst.mem[{rf[5][5:0], rf[6]}], 8'ha5);
        check_regs("immediate store regs");
    endtask : t_imm
    task automatic t_halt();
        logic [7:0] ops [3] = '{8'hff, 8'h00, 8'h01};
        for (int i = 0; i < 3; i++) begin
            exec(ops[i], 8'h00, 5, 0, 0);
            chk("halted", halted_o, 1'b1);
            check_regs("halt regs");
            exec(8'hc9, 8'h00, 5, 0, 0);
            chk("halt cleared", halted_o, 1'b0);
        end
    endtask : t_halt
    task automatic t_incdec();
        logic [7:0] v [6] = '{8'hff, 8'h00, 8'h7f, 8'h80, 8'h0f, 8'h3c};
        for (int i = 0; i < 6; i++) begin
            init_rf();
            rf[i + 1] = v[i];
            flg = {3'b000, i[0]};
            set_regs();
            exec({2'b00, 3'(i + 1), 3'b000}, 8'h00, 5, 0, 0);
            rf[i + 1] = v[i] + 8'h01;
            flg = nf(rf[i + 1], flg[0]);
            check_regs("increment");
            exec({2'b00, 3'(i + 1), 3'b001}, 8'h00, 5, 0, 0);
            exec({2'b00, 3'(i + 1), 3'b001}, 8'h00, 5, 0, 0);
            rf[i + 1] = v[i] - 8'h01;
            flg = nf(rf[i + 1], flg[0]);
            check_regs("decrement");
        end
    endtask : t_incdec
    task automatic t_cond();
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 2; k++) begin
                flg = k ? ~(4'b0001 << s) : (4'b0001 << s);
                bus(1'b1, `IDX_FLAGS_OFS, {28'h0, flg}, 4'h1);
                bus(1'b1, `IDX_COND_OFS, 32'(s), 4'h1);
                bus(1'b0, `IDX_COND_OFS, 32'h0, 4'hf);
                chk("selected flag", q[2:0], {2'(s), 1'(k == 0)});
            end
        end
    endtask : t_cond
    // An opcode outside the group runs five states, changes nothing and is flagged.
    task automatic t_unsup();
        exec(8'h80, 8'h3c, 5, 0, 0);
        chk("unsupported halted", halted_o, 1'b0);
        bus(1'b0, `IDX_STATUS_OFS, 32'h0, 4'hf);
        chk("status", q, 32'h0000_0514);
        bus(1'b0, `IDX_CTRL_OFS, 32'h0, 4'hf);
        chk("second byte", q, 32'h0000_3c00);
        check_regs("unsupported keeps regs");
    endtask : t_unsup
    initial begin
        rst_n_i = 1'b0;
        avs_address_i = 6'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'h0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_move();
        t_mem();
        t_imm();
        t_halt();
        t_incdec();
        t_cond();
        t_unsup();
        results();
    end
endmodule : tb
